// ==== paof_pkg.sv ====
// Constants for the port alternate-function override block.
// Assumes one 125 MHz I/O clock and active-low asynchronous reset.
`default_nettype none
package paof_pkg;
  localparam int PAOF_PA_WIDTH = 8;
  localparam int PAOF_PB_HI = 7;
  localparam int PAOF_PB_LO = 5;
  // Pin change source numbers carried by port B bits 7:5
  localparam int PAOF_PB_PC_SRC_BASE = 13;
  localparam int PAOF_SYNC_STAGES = 2;
  // Reset values of the input synchroniser and gated-input flops
  localparam logic [7:0] PAOF_PA_SYNC_RST = 8'h00;
  localparam logic [2:0] PAOF_PB_SYNC_RST = 3'h0;
  // Field positions in the packed result of one pin's override resolution
  localparam int PAOF_RES_PULLUP = 3;
  localparam int PAOF_RES_OE = 2;
  localparam int PAOF_RES_OUT = 1;
  localparam int PAOF_RES_IE = 0;
  typedef logic [3:0] paof_res_t;
endpackage
`default_nettype wire

// ==== paof_port_override.sv ====
// Alternate-function override logic for port A pins 7:0 and port B pins 7:5.
// Assumes pin levels arrive raw from the pads and peripheral controls are on clk.
//
// Contract
// - Port A pull-up, direction and value overrides stay off; port bits rule.
// - Port A input override enable is mask AND group0 enable OR converter disable.
// - Port A pins feed converter channels 7:0 directly.
// - Port A digital inputs feed pin change sources 7:0 by index.
// - SPI slave forces SCK on port B bit 7 to input.
// - SPI master leaves SCK direction to port B bit 7 direction bit.
// - A forced-input SPI pin keeps its pull-up under its output bit.
// - Timer-3 compare B drives port B bit 7 only when direction bit set.
// - SPI master forces MISO on port B bit 6 to input.
// - SPI slave leaves MISO direction to port B bit 6 direction bit.
// - Timer-3 compare A drives port B bit 6 only when direction bit set.
// - SPI slave forces MOSI on port B bit 5 to input.
// - SPI master leaves MOSI direction to port B bit 5 direction bit.
// - Port B bit 5 input is the timer-3 capture trigger.
// - Port B bits 7, 6, 5 feed pin change sources 15, 14, 13.
// - Without pull-up override, pull-up on only when direction, output, disable are 0,1,0.
// - Direction override enable makes override value drive the output enable.
// - Value override enable with driver on drives override value, not output bit.
`default_nettype none
module paof_port_override
  import paof_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sleep_active,
  input wire logic global_pullup_disable,
  input wire logic [paof_pkg::PAOF_PA_WIDTH-1:0] pa_pin_in,
  input wire logic [paof_pkg::PAOF_PA_WIDTH-1:0] pa_direction,
  input wire logic [paof_pkg::PAOF_PA_WIDTH-1:0] pa_output,
  input wire logic group0_pin_change_enable,
  input wire logic [paof_pkg::PAOF_PA_WIDTH-1:0] pin_change_mask_lo,
  input wire logic [paof_pkg::PAOF_PA_WIDTH-1:0] converter_digital_disable,
  input wire logic [paof_pkg::PAOF_PB_HI:paof_pkg::PAOF_PB_LO] pb_pin_in,
  input wire logic [paof_pkg::PAOF_PB_HI:paof_pkg::PAOF_PB_LO] pb_direction,
  input wire logic [paof_pkg::PAOF_PB_HI:paof_pkg::PAOF_PB_LO] pb_output,
  input wire logic group1_pin_change_enable,
  input wire logic [paof_pkg::PAOF_PB_HI:paof_pkg::PAOF_PB_LO] pin_change_mask_hi,
  input wire logic spi_enable,
  input wire logic spi_master,
  input wire logic spi_clock_out,
  input wire logic spi_slave_out,
  input wire logic spi_master_out,
  input wire logic timer3_compare_en_a,
  input wire logic timer3_compare_out_a,
  input wire logic timer3_compare_en_b,
  input wire logic timer3_compare_out_b,
  output logic [paof_pkg::PAOF_PA_WIDTH-1:0] pa_pad_out,
  output logic [paof_pkg::PAOF_PA_WIDTH-1:0] pa_pad_oe,
  output logic [paof_pkg::PAOF_PA_WIDTH-1:0] pa_pullup_en,
  output logic [paof_pkg::PAOF_PA_WIDTH-1:0] pa_input_en,
  output logic [paof_pkg::PAOF_PA_WIDTH-1:0] converter_analog_in,
  output logic [paof_pkg::PAOF_PA_WIDTH-1:0] pin_change_src_lo,
  output logic [paof_pkg::PAOF_PB_HI:paof_pkg::PAOF_PB_LO] pb_pad_out,
  output logic [paof_pkg::PAOF_PB_HI:paof_pkg::PAOF_PB_LO] pb_pad_oe,
  output logic [paof_pkg::PAOF_PB_HI:paof_pkg::PAOF_PB_LO] pb_pullup_en,
  output logic [paof_pkg::PAOF_PB_HI:paof_pkg::PAOF_PB_LO] pb_input_en,
  output logic [paof_pkg::PAOF_PB_HI:paof_pkg::PAOF_PB_LO] pin_change_src_hi,
  output logic spi_clock_in,
  output logic spi_master_in,
  output logic spi_slave_in,
  output logic timer3_capture_in
);
  import paof_pkg::*;

  // Generic per-pin resolution shared by every pin
  function automatic paof_res_t resolve(
    input logic pullup_override_en,
    input logic pullup_override_val,
    input logic direction_override_en,
    input logic direction_override_val,
    input logic value_override_en,
    input logic value_override_val,
    input logic input_enable_override_en,
    input logic input_enable_override_val,
    input logic pin_direction_bit,
    input logic pin_output_bit,
    input logic pull_disable,
    input logic sleeping
  );
    paof_res_t r;
    r = '0;
    r[PAOF_RES_PULLUP] = pullup_override_en ? pullup_override_val
                       : (!pin_direction_bit && pin_output_bit && !pull_disable);
    r[PAOF_RES_OE] = direction_override_en ? direction_override_val : pin_direction_bit;
    r[PAOF_RES_OUT] = value_override_en ? value_override_val : pin_output_bit;
    r[PAOF_RES_IE] = input_enable_override_en ? input_enable_override_val : !sleeping;
    return r;
  endfunction

  // Pads are asynchronous to clk
  logic [PAOF_PA_WIDTH-1:0] pa_sync1_q;
  logic [PAOF_PA_WIDTH-1:0] pa_sync2_q;
  logic [PAOF_PB_HI:PAOF_PB_LO] pb_sync1_q;
  logic [PAOF_PB_HI:PAOF_PB_LO] pb_sync2_q;
  logic [PAOF_PA_WIDTH-1:0] pa_di_q;
  logic [PAOF_PB_HI:PAOF_PB_LO] pb_di_q;
  logic [PAOF_PA_WIDTH-1:0] pa_di_d;
  logic [PAOF_PB_HI:PAOF_PB_LO] pb_di_d;

  // SPI role decode
  wire spi_as_master = spi_enable && spi_master;
  wire spi_as_slave = spi_enable && !spi_master;

  // Port A: only the input enable is overridden
  genvar gi;
  generate
    for (gi = 0; gi < PAOF_PA_WIDTH; gi++) begin : g_pa
      wire pa_pc_term = pin_change_mask_lo[gi] && group0_pin_change_enable;
      wire paof_res_t pa_res = resolve(
        1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0,
        pa_pc_term || converter_digital_disable[gi], pa_pc_term,
        pa_direction[gi], pa_output[gi], global_pullup_disable, sleep_active);
      assign pa_pullup_en[gi] = pa_res[PAOF_RES_PULLUP];
      assign pa_pad_oe[gi] = pa_res[PAOF_RES_OE];
      assign pa_pad_out[gi] = pa_res[PAOF_RES_OUT];
      assign pa_input_en[gi] = pa_res[PAOF_RES_IE];
    end
  endgenerate

  // Converter channels see the pad itself, no digital path
  assign converter_analog_in = pa_pin_in;

  // Port B 7:5 per-pin override terms
  logic [PAOF_PB_HI:PAOF_PB_LO] pb_force_in;
  logic [PAOF_PB_HI:PAOF_PB_LO] pb_vo_en;
  logic [PAOF_PB_HI:PAOF_PB_LO] pb_vo_val;
  assign pb_force_in[7] = spi_as_slave;
  assign pb_force_in[6] = spi_as_master;
  assign pb_force_in[5] = spi_as_slave;
  // SPI output takes priority over the timer when both claim the pin
  assign pb_vo_en[7] = spi_as_master || timer3_compare_en_b;
  assign pb_vo_val[7] = spi_as_master ? spi_clock_out : timer3_compare_out_b;
  assign pb_vo_en[6] = spi_as_slave || timer3_compare_en_a;
  assign pb_vo_val[6] = spi_as_slave ? spi_slave_out : timer3_compare_out_a;
  assign pb_vo_en[5] = spi_as_master;
  assign pb_vo_val[5] = spi_master_out;

  generate
    for (gi = PAOF_PB_LO; gi <= PAOF_PB_HI; gi++) begin : g_pb
      wire paof_res_t pb_res = resolve(
        pb_force_in[gi], pb_output[gi] && !global_pullup_disable,
        pb_force_in[gi], 1'b0,
        pb_vo_en[gi], pb_vo_val[gi],
        pin_change_mask_hi[gi] && group1_pin_change_enable, 1'b1,
        pb_direction[gi], pb_output[gi], global_pullup_disable, sleep_active);
      assign pb_pullup_en[gi] = pb_res[PAOF_RES_PULLUP];
      assign pb_pad_oe[gi] = pb_res[PAOF_RES_OE];
      assign pb_pad_out[gi] = pb_res[PAOF_RES_OUT];
      assign pb_input_en[gi] = pb_res[PAOF_RES_IE];
    end
  endgenerate

  // Disabled inputs read low so sleeping pads do not toggle peripherals
  assign pa_di_d = pa_sync2_q & pa_input_en;
  assign pb_di_d = pb_sync2_q & pb_input_en;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pa_sync1_q <= PAOF_PA_SYNC_RST;
      pa_sync2_q <= PAOF_PA_SYNC_RST;
      pb_sync1_q <= PAOF_PB_SYNC_RST;
      pb_sync2_q <= PAOF_PB_SYNC_RST;
      pa_di_q <= PAOF_PA_SYNC_RST;
      pb_di_q <= PAOF_PB_SYNC_RST;
    end else begin
      pa_sync1_q <= pa_pin_in;
      pa_sync2_q <= pa_sync1_q;
      pb_sync1_q <= pb_pin_in;
      pb_sync2_q <= pb_sync1_q;
      pa_di_q <= pa_di_d;
      pb_di_q <= pb_di_d;
    end
  end

  assign pin_change_src_lo = pa_di_q;
  assign pin_change_src_hi = pb_di_q;
  assign spi_clock_in = pb_di_q[7];
  assign spi_master_in = pb_di_q[6];
  assign spi_slave_in = pb_di_q[5];
  assign timer3_capture_in = pb_di_q[5];

  // Checks
  pa_no_override_a: assert property (@(posedge clk) disable iff (!rst_n)
    pa_pad_oe == pa_direction && pa_pad_out == pa_output)
    else $error("port A direction or value overridden");
  pa_input_ovr_a: assert property (@(posedge clk) disable iff (!rst_n)
    (converter_digital_disable[0] && !(pin_change_mask_lo[0] && group0_pin_change_enable))
    |-> !pa_input_en[0])
    else $error("port A input not disabled by converter");
  pa_pullup_a: assert property (@(posedge clk) disable iff (!rst_n)
    pa_pullup_en == (~pa_direction & pa_output & {PAOF_PA_WIDTH{!global_pullup_disable}}))
    else $error("port A pull-up mismatch");
  sck_slave_in_a: assert property (@(posedge clk) disable iff (!rst_n)
    spi_as_slave |-> !pb_pad_oe[7] && pb_pullup_en[7] == (pb_output[7] && !global_pullup_disable))
    else $error("SCK not input as slave");
  miso_master_in_a: assert property (@(posedge clk) disable iff (!rst_n)
    spi_as_master |-> !pb_pad_oe[6])
    else $error("MISO not input as master");
  mosi_master_out_a: assert property (@(posedge clk) disable iff (!rst_n)
    spi_as_master |-> pb_pad_oe[5] == pb_direction[5] && pb_pad_out[5] == spi_master_out)
    else $error("MOSI master drive wrong");
  t3b_drive_a: assert property (@(posedge clk) disable iff (!rst_n)
    (timer3_compare_en_b && !spi_enable && pb_direction[7])
    |-> pb_pad_oe[7] && pb_pad_out[7] == timer3_compare_out_b)
    else $error("compare B not on pin");
  capture_path_a: assert property (@(posedge clk) disable iff (!rst_n)
    (pb_pin_in[5] && pb_input_en[5]) [*4] |-> timer3_capture_in)
    else $error("capture input lost");
  pa_pc_path_a: assert property (@(posedge clk) disable iff (!rst_n)
    (pa_pin_in[3] && pa_input_en[3]) [*4] |-> pin_change_src_lo[3])
    else $error("pin change source 3 lost");

  // Port A analog and input-enable resolution
  pa_analog_a: assert property (@(posedge clk) disable iff (!rst_n)
    converter_analog_in == pa_pin_in)
    else $error("converter input not tied to pad");
  pa_ie_on_a: assert property (@(posedge clk) disable iff (!rst_n)
    (pin_change_mask_lo[4] && group0_pin_change_enable) |-> pa_input_en[4])
    else $error("port A input not enabled by pin change");
  pa_ie_conv_a: assert property (@(posedge clk) disable iff (!rst_n)
    (converter_digital_disable & ~(pin_change_mask_lo & {8{group0_pin_change_enable}}) & pa_input_en) == 8'h00)
    else $error("converter disable not applied");
  pa_ie_sleep_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!converter_digital_disable[6] && !(pin_change_mask_lo[6] && group0_pin_change_enable))
    |-> pa_input_en[6] == !sleep_active)
    else $error("port A input enable ignores sleep");
  pa_ie_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!pa_input_en[1]) [*2] |-> !pin_change_src_lo[1])
    else $error("disabled port A input not read low");
  pa_pc_low_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!pa_pin_in[0]) [*4] |-> !pin_change_src_lo[0])
    else $error("pin change source 0 stuck high");
  pa_indep_a: assert property (@(posedge clk) disable iff (!rst_n)
    spi_enable |-> pa_pad_oe == pa_direction && pa_pad_out == pa_output)
    else $error("port A disturbed by SPI override");

  // Port B direction, value and pull-up resolution
  sck_master_dir_a: assert property (@(posedge clk) disable iff (!rst_n)
    spi_as_master |-> pb_pad_oe[7] == pb_direction[7])
    else $error("SCK direction not from port bit as master");
  sck_master_val_a: assert property (@(posedge clk) disable iff (!rst_n)
    (spi_as_master && pb_direction[7]) |-> pb_pad_out[7] == spi_clock_out)
    else $error("SCK not driven by SPI clock");
  miso_slave_drive_a: assert property (@(posedge clk) disable iff (!rst_n)
    spi_as_slave |-> pb_pad_oe[6] == pb_direction[6] && pb_pad_out[6] == spi_slave_out)
    else $error("MISO slave drive wrong");
  mosi_slave_in_a: assert property (@(posedge clk) disable iff (!rst_n)
    spi_as_slave |-> !pb_pad_oe[5])
    else $error("MOSI not input as slave");
  miso_pullup_a: assert property (@(posedge clk) disable iff (!rst_n)
    spi_as_master |-> pb_pullup_en[6] == (pb_output[6] && !global_pullup_disable))
    else $error("forced MISO pull-up wrong");
  mosi_pullup_a: assert property (@(posedge clk) disable iff (!rst_n)
    spi_as_slave |-> pb_pullup_en[5] == (pb_output[5] && !global_pullup_disable))
    else $error("forced MOSI pull-up wrong");
  pb_indep_a: assert property (@(posedge clk) disable iff (!rst_n)
    spi_as_master |-> pb_pullup_en[7] == (!pb_direction[7] && pb_output[7] && !global_pullup_disable))
    else $error("SCK pull-up disturbed by MISO override");
  forced_oe_a: assert property (@(posedge clk) disable iff (!rst_n)
    (pb_pad_oe & pb_force_in) == 3'h0)
    else $error("forced input pin still driven");
  t3a_drive_a: assert property (@(posedge clk) disable iff (!rst_n)
    (timer3_compare_en_a && !spi_enable && pb_direction[6])
    |-> pb_pad_oe[6] && pb_pad_out[6] == timer3_compare_out_a)
    else $error("compare A not on pin");
  t3_dir_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    !spi_enable |-> pb_pad_oe == pb_direction)
    else $error("timer pin driven without direction bit");
  pb_pullup_a: assert property (@(posedge clk) disable iff (!rst_n)
    !spi_enable |-> pb_pullup_en == (~pb_direction & pb_output & {3{!global_pullup_disable}}))
    else $error("port B pull-up mismatch");
  pullup_off_a: assert property (@(posedge clk) disable iff (!rst_n)
    global_pullup_disable |-> pb_pullup_en == 3'h0 && pa_pullup_en == 8'h00)
    else $error("pull-up on while globally disabled");
  pb_plain_out_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!spi_enable && !timer3_compare_en_a && !timer3_compare_en_b) |-> pb_pad_out == pb_output)
    else $error("port B value overridden while idle");

  // Port B digital input paths
  pb_ie_ovr_a: assert property (@(posedge clk) disable iff (!rst_n)
    ((pin_change_mask_hi & {3{group1_pin_change_enable}}) & ~pb_input_en) == 3'h0)
    else $error("port B input override not applied");
  pb_ie_sleep_a: assert property (@(posedge clk) disable iff (!rst_n)
    !group1_pin_change_enable |-> pb_input_en == {3{!sleep_active}})
    else $error("port B input enable ignores sleep");
  pb_ie_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!pb_input_en[5]) [*2] |-> !timer3_capture_in)
    else $error("disabled capture input not read low");
  pb_pc_path_a: assert property (@(posedge clk) disable iff (!rst_n)
    (pb_pin_in[7] && pb_input_en[7]) [*4] |-> pin_change_src_hi[7])
    else $error("pin change source 15 lost");
  pb_pc_low_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!pb_pin_in[6]) [*4] |-> !pin_change_src_hi[6])
    else $error("pin change source 14 stuck high");
  capture_low_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!pb_pin_in[5]) [*4] |-> !timer3_capture_in)
    else $error("capture input stuck high");
endmodule
`default_nettype wire

// ==== paof_periph_model.sv ====
// Peripheral-side model: SPI drive values and timer-3 compare waveforms.
// Assumes the bench owns all enables; values move on the rising edge.
`default_nettype none
module paof_periph_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic spi_active,
  output logic spi_clock_out,
  output logic spi_slave_out,
  output logic spi_master_out,
  output logic timer3_compare_out_a,
  output logic timer3_compare_out_b
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) cnt_q <= 4'h0;
    else cnt_q <= cnt_q + 4'h1;
  end
  // Serial clock stands still while the SPI is idle
  assign spi_clock_out = spi_active & cnt_q[0];
  assign spi_slave_out = cnt_q[1];
  assign spi_master_out = ~cnt_q[2];
  assign timer3_compare_out_a = ~cnt_q[0];
  assign timer3_compare_out_b = cnt_q[3];
endmodule
`default_nettype wire

// ==== port_alt_function_override_test.sv ====
// Self-checking bench for the port alternate-function override block.
// Assumes the peripheral model drives SPI and timer values; outputs checked at falling edge.
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_errors++; $display("wrong value at %0t: output mismatch", $time); end end
module port_alt_function_override_test;
  timeunit 1ns;
  timeprecision 1ps;
  import paof_pkg::*;
  int n_errors = 0;
  int n_compared = 0;
  logic clk = 0, rst_n = 0, sleep_active = 0, global_pullup_disable = 0, group0_pin_change_enable = 0;
  logic group1_pin_change_enable = 0, spi_enable = 0, spi_master = 0, timer3_compare_en_a = 0, timer3_compare_en_b = 0;
  logic [7:0] pa_pin_in = 8'h00, pa_direction = 8'h00, pa_output = 8'h00, pin_change_mask_lo = 8'h00;
  logic [7:0] converter_digital_disable = 8'h00;
  logic [7:5] pb_pin_in = 3'h0, pb_direction = 3'h0, pb_output = 3'h0, pin_change_mask_hi = 3'h0;
  logic spi_clock_out, spi_slave_out, spi_master_out, timer3_compare_out_a, timer3_compare_out_b;
  logic [7:0] pa_pad_out, pa_pad_oe, pa_pullup_en, pa_input_en, converter_analog_in, pin_change_src_lo;
  logic [7:5] pb_pad_out, pb_pad_oe, pb_pullup_en, pb_input_en, pin_change_src_hi;
  logic spi_clock_in, spi_master_in, spi_slave_in, timer3_capture_in;
  always #4 clk = ~clk;
  paof_periph_model model (.clk, .rst_n, .spi_active(spi_enable), .spi_clock_out, .spi_slave_out, .spi_master_out,
    .timer3_compare_out_a, .timer3_compare_out_b);
  paof_port_override uut (.clk, .rst_n, .sleep_active, .global_pullup_disable, .pa_pin_in, .pa_direction, .pa_output,
    .group0_pin_change_enable, .pin_change_mask_lo, .converter_digital_disable, .pb_pin_in, .pb_direction, .pb_output,
    .group1_pin_change_enable, .pin_change_mask_hi, .spi_enable, .spi_master, .spi_clock_out, .spi_slave_out,
    .spi_master_out, .timer3_compare_en_a, .timer3_compare_out_a, .timer3_compare_en_b, .timer3_compare_out_b,
    .pa_pad_out, .pa_pad_oe, .pa_pullup_en, .pa_input_en, .converter_analog_in, .pin_change_src_lo, .pb_pad_out,
    .pb_pad_oe, .pb_pullup_en, .pb_input_en, .pin_change_src_hi, .spi_clock_in, .spi_master_in, .spi_slave_in,
    .timer3_capture_in);
  task automatic end_of_test;
    if (n_errors == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Port A pad control follows port bits alone, within the cycle
  task automatic t_port_a;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      pa_direction <= 8'h5a ^ {8{i[0]}};
      pa_output <= 8'h33 ^ {8{i[1]}};
      global_pullup_disable <= i[0] & i[1];
      pa_pin_in <= 8'hc6 ^ {8{i[0]}};
      @(negedge clk);
      `CHK(pa_pad_oe, pa_direction)
      `CHK(pa_pad_out, pa_output)
      `CHK(pa_pullup_en, ~pa_direction & pa_output & {8{~global_pullup_disable}})
      `CHK(converter_analog_in, pa_pin_in)
    end
  endtask
  task automatic t_pa_input;
    logic [7:0] en_v, val_v, ie_v;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      sleep_active <= i[0];
      group0_pin_change_enable <= i[1];
      pin_change_mask_lo <= 8'h96;
      converter_digital_disable <= 8'h0c;
      pa_pin_in <= 8'hff;
      // Gated pin change path needs three edges to settle
      repeat (4) @(posedge clk);
      @(negedge clk);
      val_v = pin_change_mask_lo & {8{group0_pin_change_enable}};
      en_v = val_v | converter_digital_disable;
      ie_v = (en_v & val_v) | (~en_v & {8{~sleep_active}});
      `CHK(pa_input_en, ie_v)
      `CHK(pin_change_src_lo, ie_v & pa_pin_in)
    end
  endtask
  task automatic t_spi;
    logic [7:5] oe_v, frc_v;
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      spi_enable <= 1'b1;
      spi_master <= k[0];
      pb_direction <= k[1] ? 3'b010 : 3'b111;
      pb_output <= 3'b101;
      global_pullup_disable <= 1'b0;
      @(negedge clk);
      frc_v = spi_master ? 3'b010 : 3'b101;
      oe_v = pb_direction & ~frc_v;
      `CHK(pb_pad_oe, oe_v)
      `CHK(pb_pullup_en, (frc_v & pb_output) | (~frc_v & ~pb_direction & pb_output))
      if (spi_master) `CHK(pb_pad_out & oe_v, {spi_clock_out, 1'b0, spi_master_out} & oe_v)
      else `CHK(pb_pad_out & oe_v, {1'b0, spi_slave_out, 1'b0} & oe_v)
    end
  endtask
  task automatic t_timer;
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      spi_enable <= 1'b0;
      timer3_compare_en_a <= 1'b1;
      timer3_compare_en_b <= 1'b1;
      pb_direction <= k[1] ? 3'b000 : 3'b111;
      @(negedge clk);
      `CHK(pb_pad_oe, pb_direction)
      `CHK(pb_pad_out & pb_direction, {timer3_compare_out_b, timer3_compare_out_a, pb_output[5]} & pb_direction)
    end
  endtask
  task automatic t_pb_inputs;
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      pb_direction <= 3'b000;
      sleep_active <= 1'b1;
      group1_pin_change_enable <= 1'b1;
      pin_change_mask_hi <= 3'b111;
      pb_pin_in <= k[0] ? 3'b010 : 3'b101;
      repeat (4) @(posedge clk);
      @(negedge clk);
      `CHK(pb_input_en, 3'b111)
      `CHK(pin_change_src_hi, pb_pin_in)
      `CHK(timer3_capture_in, pb_pin_in[5])
      `CHK({spi_clock_in, spi_master_in, spi_slave_in}, pb_pin_in)
    end
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_port_a();
    t_pa_input();
    t_spi();
    t_timer();
    t_pb_inputs();
    end_of_test();
  end
  initial begin
    #(2000 * 8);
    n_errors++;
    end_of_test();
  end
endmodule
`default_nettype wire
